// [shared/bpu_cfg.svh]
// constants for the branch and pc update unit
`ifndef BPU_CFG_SVH
`define BPU_CFG_SVH
`define BPU_XLEN 32
`define BPU_PC_OFS 32'h0000_0004
`define BPU_HW_STEP 32'h0000_0002
`define BPU_W_STEP 32'h0000_0004
`define BPU_ALIGN_MASK 32'hFFFF_FFFC
`define BPU_LINK_STATE 32'h0000_0001
`define BPU_COND_RANGE_LO 32'hFFFF_FF00
`define BPU_COND_RANGE_HI 32'h0000_00FE
// 16-bit encodings, first halfword
`define BPU_P_UDF16 16'b11011110????????
`define BPU_P_SVC 16'b11011111????????
`define BPU_P_BCOND 16'b1101????????????
`define BPU_P_B 16'b11100???????????
`define BPU_P_RJUMP 16'b010001110????000
`define BPU_P_RCALL 16'b010001111????000
`define BPU_P_SUMPC 16'b010001001????111
`define BPU_P_COPYPC 16'b010001101????111
`define BPU_P_POPPC 16'b10111101????????
`define BPU_P_DEBUG_HALT_TRAP 16'b10111110????????
`define BPU_P_CMPJ 16'b1011?0?1????????
`define BPU_P_HINT 16'b10111111????????
`define BPU_P_LIT 16'b01001???????????
`define BPU_P_ADR 16'b10100???????????
// 32-bit encodings, with the 16-bit short branch that shares their prefix
`define BPU_P_WIDE 16'b111?????????????
`define BPU_P_NARROW_B 16'b11100???????????
`define BPU_P_UDF32_HI 12'hF7F
`define BPU_P_UDF32_LO 4'hA
`define BPU_P_BL_HI 5'h1E
`define BPU_P_SYS_OP 3'h7
`endif

// [shared/bpu_pkg.sv]
// types for the branch and pc update unit
`include "bpu_cfg.svh"
package bpu_pkg;
    typedef enum logic [3:0] {
        BPU_C_OTHER16, BPU_C_OTHER32, BPU_C_JUMP, BPU_C_JUMP_COND,
        BPU_C_CALL_LONG, BPU_C_REG_JUMP, BPU_C_REG_CALL, BPU_C_SUM_PC,
        BPU_C_COPY_PC, BPU_C_POP_PC, BPU_C_TRAP_DBG, BPU_C_TRAP_SVC,
        BPU_C_LIT_LOAD, BPU_C_PC_ADR, BPU_C_PERM_UNDEF, BPU_C_UNSUP
    } bpu_class_t;
    typedef struct packed {logic n; logic z; logic c; logic v;} bpu_flags_t;
    typedef struct packed {
        logic valid;
        logic [`BPU_XLEN-1:0] instr;
        logic [`BPU_XLEN-1:0] addr;
    } bpu_req_t;
    typedef struct packed {
        bpu_class_t cls;
        logic is32;
        logic [3:0] cond;
        logic [`BPU_XLEN-1:0] imm;
    } bpu_dec_t;
    typedef struct packed {
        logic vld; logic is32; logic adv; logic pc_we; logic link_we;
        logic fault; logic exc_dbg; logic exc_svc; logic undef;
        logic lit_we; logic adr_we;
        logic [`BPU_XLEN-1:0] addr;
        logic [`BPU_XLEN-1:0] next;
        logic [`BPU_XLEN-1:0] pc;
        logic [`BPU_XLEN-1:0] link;
        logic [`BPU_XLEN-1:0] pcrel;
    } bpu_res_t;
endpackage

// [rtl/bpu_decode.sv]
// instruction class and immediate decoder
`timescale 1ns/1ns
`include "bpu_cfg.svh"
module bpu_decode (
    // instruction, first halfword in the low half
    input wire logic [`BPU_XLEN-1:0] instr_i,
    // decoded class, width and offset
    output bpu_pkg::bpu_dec_t dec_o
);
    import bpu_pkg::*;
    logic [15:0] hw1;
    logic [15:0] hw2;
    logic s_bit;
    assign hw1 = instr_i[15:0];
    assign hw2 = instr_i[31:16];
    assign s_bit = hw1[10];

    // width is a property of the encoding alone, never of the class
    always_comb begin
        dec_o = '0;
        dec_o.cond = hw1[11:8];
        casez (hw1)
            `BPU_P_NARROW_B: dec_o.is32 = 1'b0;
            `BPU_P_WIDE: dec_o.is32 = 1'b1;
            default: dec_o.is32 = 1'b0;
        endcase
        if (dec_o.is32) begin
            if (hw1[15:4] == `BPU_P_UDF32_HI
                    && hw2[15:12] == `BPU_P_UDF32_LO) begin
                dec_o.cls = BPU_C_PERM_UNDEF;
            end else if (hw1[15:11] == `BPU_P_BL_HI
                    && hw2[15:14] == 2'h3 && hw2[12]) begin
                dec_o.cls = BPU_C_CALL_LONG;
                dec_o.imm = {{7{s_bit}}, s_bit, ~(hw2[13] ^ s_bit),
                    ~(hw2[11] ^ s_bit), hw1[9:0], hw2[10:0], 1'b0};
            end else if (hw1[15:11] == `BPU_P_BL_HI && hw2[15:14] == 2'h2
                    && !hw2[12] && hw1[9:7] == `BPU_P_SYS_OP) begin
                dec_o.cls = BPU_C_OTHER32;
            end else begin
                // wide conditional branch and the rest are absent
                dec_o.cls = BPU_C_UNSUP;
            end
        end else begin
            priority casez (hw1)
                `BPU_P_UDF16: dec_o.cls = BPU_C_PERM_UNDEF;
                `BPU_P_SVC: dec_o.cls = BPU_C_TRAP_SVC;
                `BPU_P_BCOND: begin
                    dec_o.cls = BPU_C_JUMP_COND;
                    dec_o.imm = {{23{hw1[7]}}, hw1[7:0], 1'b0};
                end
                `BPU_P_B: begin
                    dec_o.cls = BPU_C_JUMP;
                    dec_o.imm = {{20{hw1[10]}}, hw1[10:0], 1'b0};
                end
                `BPU_P_RJUMP: dec_o.cls = BPU_C_REG_JUMP;
                `BPU_P_RCALL: dec_o.cls = BPU_C_REG_CALL;
                `BPU_P_SUMPC: dec_o.cls = BPU_C_SUM_PC;
                `BPU_P_COPYPC: dec_o.cls = BPU_C_COPY_PC;
                `BPU_P_POPPC: dec_o.cls = BPU_C_POP_PC;
                `BPU_P_DEBUG_HALT_TRAP: dec_o.cls = BPU_C_TRAP_DBG;
                `BPU_P_CMPJ: dec_o.cls = BPU_C_UNSUP;
                // hint space; a nonzero mask would be an if_then_group
                `BPU_P_HINT: dec_o.cls =
                    (hw1[3:0] != 4'h0) ? BPU_C_UNSUP : BPU_C_OTHER16;
                `BPU_P_LIT: begin
                    dec_o.cls = BPU_C_LIT_LOAD;
                    dec_o.imm = {22'h0, hw1[7:0], 2'h0};
                end
                `BPU_P_ADR: begin
                    dec_o.cls = BPU_C_PC_ADR;
                    dec_o.imm = {22'h0, hw1[7:0], 2'h0};
                end
                default: dec_o.cls = BPU_C_OTHER16;
            endcase
        end
    end
endmodule // bpu_decode

// [rtl/bpu_branch_unit.sv]
// branch and program counter update unit
`timescale 1ns/1ns
`include "bpu_cfg.svh"

module bpu_branch_unit (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // instruction from decode, with operands read for it
    input bpu_pkg::bpu_req_t req_i,
    input bpu_pkg::bpu_flags_t flags_i,
    input wire logic [`BPU_XLEN-1:0] rm_val_i,
    input wire logic [`BPU_XLEN-1:0] pop_val_i,
    // pc update result, one cycle later
    output bpu_pkg::bpu_res_t res_o
);
    import bpu_pkg::*;

    bpu_dec_t dec;
    bpu_res_t res_d;
    bpu_res_t res_q;
    logic [`BPU_XLEN-1:0] pc_val;
    logic [`BPU_XLEN-1:0] pc_word;
    logic [`BPU_XLEN-1:0] seq_pc;
    logic [`BPU_XLEN-1:0] iw_val;
    logic iw_cls;
    logic pass;

    // pc write form: bit 0 is never stored
    function automatic logic [`BPU_XLEN-1:0] write_pc(
        input logic [`BPU_XLEN-1:0] v);
        write_pc = {v[`BPU_XLEN-1:1], 1'b0};
    endfunction

    // link value keeps the only supported execution state
    function automatic logic [`BPU_XLEN-1:0] link_of(
        input logic [`BPU_XLEN-1:0] v);
        link_of = v | `BPU_LINK_STATE;
    endfunction

    // condition test on negative, zero, carry and overflow
    function automatic logic cond_pass(input logic [3:0] cc,
        input bpu_flags_t f);
        logic r;
        r = 1'b0;
        unique case (cc[3:1])
            3'h0: r = f.z;
            3'h1: r = f.c;
            3'h2: r = f.n;
            3'h3: r = f.v;
            3'h4: r = f.c && !f.z;
            3'h5: r = (f.n == f.v);
            3'h6: r = !f.z && (f.n == f.v);
            3'h7: r = 1'b1;
        endcase
        cond_pass = (cc[0] && cc[3:1] != 3'h7) ? !r : r;
    endfunction

    bpu_decode u_dec (
        .instr_i(req_i.instr),
        .dec_o(dec)
    );

    // pc as the instruction sees it, and its word-aligned form
    assign pc_val = req_i.addr + `BPU_PC_OFS;
    assign pc_word = pc_val & `BPU_ALIGN_MASK;
    // narrow and wide instructions mix freely in the stream
    assign seq_pc = req_i.addr
        + (dec.is32 ? `BPU_W_STEP : `BPU_HW_STEP);
    assign pass = cond_pass(dec.cond, flags_i);

    // interworking value: register operand or the popped word
    assign iw_cls = dec.cls == BPU_C_REG_JUMP
        || dec.cls == BPU_C_REG_CALL
        || dec.cls == BPU_C_POP_PC;
    assign iw_val = (dec.cls == BPU_C_POP_PC) ? pop_val_i
        : rm_val_i;

    // result of one instruction; a fault blocks every side effect
    always_comb begin
        res_d = '0;
        res_d.vld = req_i.valid;
        res_d.is32 = dec.is32;
        res_d.addr = req_i.addr;
        res_d.next = seq_pc;
        if (!req_i.valid) begin
            res_d = '0;
        end else if (req_i.addr[0]) begin
            // fetch off a halfword boundary cannot execute
            res_d.fault = 1'b1;
        end else begin
            unique case (dec.cls)
                BPU_C_JUMP: begin
                    res_d.pc_we = 1'b1;
                    res_d.pc = write_pc(pc_val + dec.imm);
                end
                BPU_C_JUMP_COND: begin
                    // failed test: sequential advance only
                    res_d.pc_we = pass;
                    res_d.pc = write_pc(pc_val + dec.imm);
                end
                BPU_C_CALL_LONG: begin
                    // state comes from the encoding, not from bit 0
                    res_d.pc_we = 1'b1;
                    res_d.pc = write_pc(pc_val + dec.imm);
                    res_d.link_we = 1'b1;
                    res_d.link = link_of(seq_pc);
                end
                BPU_C_REG_JUMP, BPU_C_REG_CALL, BPU_C_POP_PC: begin
                    if (!iw_val[0]) begin
                        // precise: nothing at the target runs
                        res_d.fault = 1'b1;
                    end else begin
                        res_d.pc_we = 1'b1;
                        res_d.pc = write_pc(iw_val);
                        res_d.link_we = dec.cls == BPU_C_REG_CALL;
                        res_d.link = (dec.cls == BPU_C_REG_CALL)
                            ? link_of(seq_pc) : '0;
                    end
                end
                BPU_C_SUM_PC: begin
                    res_d.pc_we = 1'b1;
                    res_d.pc = write_pc(pc_val + rm_val_i);
                end
                BPU_C_COPY_PC: begin
                    res_d.pc_we = 1'b1;
                    res_d.pc = write_pc(rm_val_i);
                end
                BPU_C_TRAP_DBG: res_d.exc_dbg = 1'b1;
                BPU_C_TRAP_SVC: res_d.exc_svc = 1'b1;
                BPU_C_LIT_LOAD: begin
                    res_d.lit_we = 1'b1;
                    res_d.pcrel = pc_word + dec.imm;
                end
                BPU_C_PC_ADR: begin
                    res_d.adr_we = 1'b1;
                    res_d.pcrel = pc_word + dec.imm;
                end
                BPU_C_PERM_UNDEF, BPU_C_UNSUP: begin
                    // undefined and absent forms both trap
                    res_d.undef = 1'b1;
                end
                BPU_C_OTHER16, BPU_C_OTHER32: ;
            endcase
        end
        res_d.adv = res_d.vld && !res_d.pc_we && !res_d.fault
            && !res_d.exc_dbg && !res_d.exc_svc
            && !res_d.undef;
    end

    // single result register; outputs come only from here
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign res_o = res_q;

    // checks, all on the core clock
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_iw_fault;
        req_i.valid && !req_i.addr[0] && iw_cls && !iw_val[0]
            |=> res_q.fault && !res_q.pc_we && !res_q.link_we;
    endproperty
    a_iw_fault: assert property (p_iw_fault)
        else $error("bad interworking value did not fault");

    property p_bit0;
        res_q.pc_we |-> !res_q.pc[0];
    endproperty
    a_bit0: assert property (p_bit0)
        else $error("pc written with bit 0 set");

    property p_sum_copy;
        req_i.valid && !req_i.addr[0]
            && (dec.cls == BPU_C_SUM_PC || dec.cls == BPU_C_COPY_PC)
            |=> res_q.pc_we && !res_q.fault
            && res_q.pc[`BPU_XLEN-1:1] == ($past(dec.cls) == BPU_C_SUM_PC
            ? $past(pc_val + rm_val_i) : $past(rm_val_i))
            >> 1;
    endproperty
    a_sum_copy: assert property (p_sum_copy)
        else $error("register form pc write wrong or faulted");

    property p_jump_target;
        req_i.valid && !req_i.addr[0] && dec.cls == BPU_C_JUMP
            |=> res_q.pc_we && !res_q.fault
            && res_q.pc == write_pc($past(req_i.addr) + `BPU_PC_OFS
            + $past(dec.imm));
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("short jump target wrong");

    property p_reg_ok;
        req_i.valid && !req_i.addr[0] && iw_cls && iw_val[0]
            |=> res_q.pc_we && !res_q.fault
            && res_q.pc == write_pc($past(iw_val))
            && res_q.link_we == ($past(dec.cls) == BPU_C_REG_CALL);
    endproperty
    a_reg_ok: assert property (p_reg_ok)
        else $error("checked register branch wrong");

    property p_pop_src;
        req_i.valid && dec.cls == BPU_C_POP_PC && !req_i.addr[0]
            |=> res_q.fault == !$past(pop_val_i[0]);
    endproperty
    a_pop_src: assert property (p_pop_src)
        else $error("pop check not on loaded value");

    property p_trap;
        req_i.valid && !req_i.addr[0]
            && (dec.cls == BPU_C_TRAP_DBG || dec.cls == BPU_C_TRAP_SVC)
            |=> (res_q.exc_dbg ^ res_q.exc_svc) && !res_q.fault
            && !res_q.pc_we && !res_q.adv;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap did not raise exception");

    property p_long_call;
        req_i.valid && !req_i.addr[0] && dec.cls == BPU_C_CALL_LONG
            |=> res_q.pc_we && res_q.link_we && !res_q.fault
            && res_q.link == ($past(req_i.addr) + `BPU_W_STEP
            | `BPU_LINK_STATE);
    endproperty
    a_long_call: assert property (p_long_call)
        else $error("long call link or state wrong");

    property p_wide_pc;
        res_q.pc_we && res_q.is32 |-> $past(dec.cls) == BPU_C_CALL_LONG;
    endproperty
    a_wide_pc: assert property (p_wide_pc)
        else $error("wide instruction other than long call wrote pc");

    sequence s_cond_fail;
        req_i.valid && !req_i.addr[0] && dec.cls == BPU_C_JUMP_COND
            && !pass;
    endsequence
    property p_cond_fail;
        s_cond_fail |=> res_q.adv && !res_q.pc_we && !res_q.fault
            && res_q.next == $past(req_i.addr) + `BPU_HW_STEP;
    endproperty
    a_cond_fail: assert property (p_cond_fail)
        else $error("failed condition did not act as no-op");

    property p_cond_range;
        req_i.valid && dec.cls == BPU_C_JUMP_COND
            |-> !dec.is32 && ($signed(dec.imm)
            >= $signed(`BPU_COND_RANGE_LO))
            && ($signed(dec.imm) <= $signed(`BPU_COND_RANGE_HI));
    endproperty
    a_cond_range: assert property (p_cond_range)
        else $error("conditional offset out of range");

    property p_undef;
        req_i.valid && !req_i.addr[0] && (dec.cls == BPU_C_UNSUP
            || dec.cls == BPU_C_PERM_UNDEF)
            |=> res_q.undef && !res_q.pc_we && !res_q.adv
            && !res_q.lit_we && !res_q.adr_we;
    endproperty
    a_undef: assert property (p_undef)
        else $error("absent encoding executed");

    property p_udf16;
        req_i.valid && req_i.instr[15:8] == 8'hDE && !req_i.addr[0]
            |=> res_q.undef && !res_q.exc_svc;
    endproperty
    a_udf16: assert property (p_udf16)
        else $error("narrow undefined op not trapped");

    property p_pcrel;
        req_i.valid && !req_i.addr[0]
            && (dec.cls == BPU_C_LIT_LOAD || dec.cls == BPU_C_PC_ADR)
            |=> (res_q.lit_we ^ res_q.adr_we)
            && res_q.pcrel[1:0] == 2'h0
            && res_q.pcrel == (($past(req_i.addr) + `BPU_PC_OFS)
            & `BPU_ALIGN_MASK) + $past(dec.imm);
    endproperty
    a_pcrel: assert property (p_pcrel)
        else $error("pc relative address wrong");

    property p_width;
        req_i.valid |=> res_q.next - res_q.addr
            == ($past(dec.is32) ? `BPU_W_STEP : `BPU_HW_STEP);
    endproperty
    a_width: assert property (p_width)
        else $error("sequential step does not match width");

    property p_one_width;
        req_i.valid && (dec.cls == BPU_C_CALL_LONG
            || dec.cls == BPU_C_OTHER32) |-> dec.is32;
    endproperty
    a_one_width: assert property (p_one_width)
        else $error("wide-only class decoded narrow");

    property p_precise;
        res_q.fault |-> !res_q.pc_we && !res_q.adv
            && res_q.addr == $past(req_i.addr);
    endproperty
    a_precise: assert property (p_precise)
        else $error("fault not tied to its instruction");

    property p_idle;
        !req_i.valid |=> res_q == '0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("result without request");

    // a link write always goes with a taken, state-keeping branch
    property p_link_state;
        res_q.link_we |-> res_q.link[0] && res_q.pc_we && !res_q.fault;
    endproperty
    a_link_state: assert property (p_link_state)
        else $error("link written without state bit or branch");

    // supported non-branch forms must not be mistaken for absent ones
    property p_other;
        req_i.valid && !req_i.addr[0]
            && (dec.cls == BPU_C_OTHER16 || dec.cls == BPU_C_OTHER32)
            |=> res_q.adv && !res_q.pc_we && !res_q.undef;
    endproperty
    a_other: assert property (p_other)
        else $error("zero-mask hint or system op trapped");
endmodule // bpu_branch_unit

// [tb/bpu_fetch_model.sv]
// fetch and decode stage model feeding the branch unit
`timescale 1ns/1ns
module bpu_fetch_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // instruction and operands from the bench
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] rm_i,
    input wire logic [31:0] pop_i,
    input bpu_pkg::bpu_flags_t flags_i,
    // toward the unit
    output bpu_pkg::bpu_req_t req_o,
    output bpu_pkg::bpu_flags_t flags_o,
    output logic [31:0] rm_o,
    output logic [31:0] pop_o
);
    import bpu_pkg::*;
    // present on the falling edge; idle operands flip so stale looks wrong
    always @(negedge core_clk_i) begin
        if (!rstn_i) begin
            // quiet while the unit is held in reset
            req_o <= '0;
            flags_o <= '0;
            rm_o <= 32'h0;
            pop_o <= 32'h0;
        end else begin
            req_o.valid <= issue_i;
            req_o.instr <= issue_i ? instr_i : ~req_o.instr;
            req_o.addr <= issue_i ? {addr_i[31:1], 1'b0}
                : ~req_o.addr;
            flags_o <= issue_i ? flags_i : ~flags_o;
            rm_o <= issue_i ? rm_i : ~rm_o;
            pop_o <= issue_i ? pop_i : ~pop_o;
        end
    end
endmodule // bpu_fetch_model

// [tb/bpu_branch_unit_tb_top.sv]
// self-checking testbench for the branch and pc update unit
`timescale 1ns/1ns
module bpu_branch_unit_tb_top;
    import bpu_pkg::*;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue = 1'b0;
    logic [31:0] t_instr = 32'h0;
    logic [31:0] t_addr = 32'h0;
    logic [31:0] t_rm = 32'h0;
    logic [31:0] t_pop = 32'h0;
    bpu_flags_t t_flags = '0;
    logic [31:0] a, rm, pop;
    bpu_flags_t f;
    bpu_req_t req;
    bpu_flags_t flags;
    logic [31:0] rm_val, pop_val;
    bpu_res_t res, mon_e;
    bpu_res_t exp_q[$];
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    bpu_fetch_model i_fetch (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .issue_i(issue), .instr_i(t_instr), .addr_i(t_addr), .rm_i(t_rm),
        .pop_i(t_pop), .flags_i(t_flags), .req_o(req), .flags_o(flags),
        .rm_o(rm_val), .pop_o(pop_val));
    bpu_branch_unit i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .req_i(req), .flags_i(flags), .rm_val_i(rm_val),
        .pop_val_i(pop_val), .res_o(res));

    // clock, 100 ns period
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] fl(input bpu_res_t r);
        return {22'h0, r.adv, r.is32, r.pc_we, r.link_we, r.fault, r.exc_dbg,
            r.exc_svc, r.undef, r.lit_we, r.adr_we};
    endfunction

    // condition check, eq..le only
    function automatic logic cond_ok(input logic [3:0] c, input bpu_flags_t x);
        logic r;
        case (c[3:1])
            3'h0: r = x.z;
            3'h1: r = x.c;
            3'h2: r = x.n;
            3'h3: r = x.v;
            3'h4: r = x.c & ~x.z;
            3'h5: r = (x.n == x.v);
            default: r = ~x.z & (x.n == x.v);
        endcase
        return c[0] ? ~r : r;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one request per call, expectation queued in issue order
    task automatic send(input logic [31:0] ins, input bpu_res_t e);
        @(negedge core_clk_i);
        t_instr <= ins;
        t_addr <= a;
        t_rm <= rm;
        t_pop <= pop;
        t_flags <= f;
        issue <= 1'b1;
        e.vld = 1'b1;
        exp_q.push_back(e);
    endtask

    // hang guard, run needs a few hundred cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            complete_run();
        end
    end

    // result watcher; unexpected result meets an all-ones note
    always @(negedge core_clk_i) begin
        if (res.vld === 1'b1) begin
            mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            cmp(fl(res), fl(mon_e));
            if (mon_e.pc_we) cmp(res.pc, mon_e.pc);
            if (mon_e.link_we) cmp(res.link, mon_e.link);
            if (mon_e.lit_we | mon_e.adr_we)
                cmp(res.pcrel, mon_e.pcrel);
            if (mon_e.fault) cmp(res.addr, mon_e.addr);
            if (mon_e.adv) cmp({31'h0, res.adv}, 32'h1);
            if (mon_e.adv) cmp(res.next, mon_e.next);
        end
    end

    initial begin
        bpu_res_t e;
        logic [31:0] w, ins, t;
        logic [3:0] c;
        logic i1, i2;
        void'($urandom(53751));
        repeat (6) @(negedge core_clk_i);
        rstn_i <= 1'b1;
        // all classes mixed, back to back with random gaps
        for (int k = 0; k < 144; k++) begin
            w = $urandom();
            a = $urandom() & 32'h00FF_FFFE;
            rm = $urandom();
            pop = $urandom();
            f = bpu_flags_t'(w[31:28]);
            c = (w[27:24] > 4'hD) ? w[27:24] - 4'h2 : w[27:24];
            e = '0;
            e.addr = a;
            i1 = ~(w[1] ^ w[0]);
            i2 = ~(w[2] ^ w[0]);
            ins = {16'h0, 5'b11100, w[10:0]};
            e.pc_we = 1'b1;
            e.pc = a + 32'h4
                + {{20{w[10]}}, w[10:0], 1'b0};
            case (k % 12)
                1: begin
                    ins = {16'h0, 4'hD, c, w[7:0]};
                    e.pc = a + 32'h4 + {{23{w[7]}}, w[7:0], 1'b0};
                    e.pc_we = cond_ok(c, f);
                    e.adv = ~e.pc_we;
                    e.next = a + 32'h2;
                end
                2: begin
                    ins = {16'h0, 8'h47, w[8], 1'b0, w[21:19], 3'h0};
                    e.pc = {rm[31:1], 1'b0};
                    e.pc_we = rm[0];
                    e.fault = ~rm[0];
                    e.link_we = rm[0] & w[8];
                    e.link = (a + 32'h2) | 32'h1;
                end
                3: begin
                    ins = {16'h0, 8'hBD, w[7:0]};
                    e.pc = {pop[31:1], 1'b0};
                    e.pc_we = pop[0];
                    e.fault = ~pop[0];
                end
                4: begin
                    ins = {16'h0, 8'h44, 2'b10, w[21:19], 3'h7};
                    t = a + 32'h4 + rm;
                    e.pc = {t[31:1], 1'b0};
                end
                5: begin
                    ins = {16'h0, 8'h46, 2'b10, w[21:19], 3'h7};
                    e.pc = {rm[31:1], 1'b0};
                end
                6: begin
                    ins = {16'h0, w[8] ? 8'hDF : 8'hBE, w[7:0]};
                    e.pc_we = 1'b0;
                    e.exc_svc = w[8];
                    e.exc_dbg = ~w[8];
                end
                7, 8: begin
                    ins = {16'h0, (k % 12 == 7) ? 5'b01001 : 5'b10100, w[10:0]};
                    e.pc_we = 1'b0;
                    e.lit_we = (k % 12 == 7);
                    e.adr_we = (k % 12 == 8);
                    e.adv = 1'b1;
                    e.next = a + 32'h2;
                    e.pcrel = ((a + 32'h4) & 32'hFFFF_FFFC)
                        + {22'h0, w[7:0], 2'h0};
                end
                9: begin
                    ins = {2'b11, w[1], 1'b1, w[2], w[23:13], 5'b11110, w[0],
                        w[12:3]};
                    e.is32 = 1'b1;
                    e.pc = a + 32'h4 + {{8{w[0]}}, i1, i2, w[12:3], w[23:13],
                        1'b0};
                    e.link_we = 1'b1;
                    e.link = (a + 32'h4) | 32'h1;
                end
                10: begin
                    ins = w[8] ? {4'hA, w[15:4], 12'hF7F, w[3:0]}
                        : {16'h0, 8'hDE, w[7:0]};
                    e = '0;
                    e.addr = a;
                    e.is32 = w[8];
                    e.undef = 1'b1;
                end
                11: begin
                    ins = {2'b10, w[1], 1'b0, w[2], w[23:13], 5'b11110, w[0],
                        c, w[29:24]};
                    if (w[9:8] == 2'h0) ins = {16'h0, 4'hB, w[0], 1'b0, w[1],
                        1'b1, w[7:0]};
                    if (w[9:8] == 2'h1) ins = {16'h0, 8'hBF, w[7:4],
                        w[3:0] | 4'h1};
                    e = '0;
                    e.addr = a;
                    e.is32 = w[9];
                    e.undef = 1'b1;
                    // zero-mask hint is a plain narrow no-op
                    if (w[9:8] == 2'h1 && w[10]) begin
                        ins[3:0] = 4'h0;
                        e.undef = 1'b0;
                        e.adv = 1'b1;
                        e.next = a + 32'h2;
                    end
                    // wide system space passes and steps by four
                    if (w[9:8] == 2'h3 && w[10]) begin
                        ins[9:6] = 4'hE;
                        e.undef = 1'b0;
                        e.adv = 1'b1;
                        e.next = a + 32'h4;
                    end
                end
                default: ;
            endcase
            if (w[30]) begin
                @(negedge core_clk_i);
                issue <= 1'b0;
            end
            send(ins, e);
        end
        @(negedge core_clk_i);
        issue <= 1'b0;
        repeat (4) @(negedge core_clk_i);
        cmp(exp_q.size(), 32'h0);
        complete_run();
    end
endmodule // bpu_branch_unit_tb_top
